// [hdl/csps_pkg.sv]
// Purpose: Constants, codes and state layout of the socket present-state block
// Assumes: 100 MHz mclk, Avalon-MM byte addresses on a 5-bit bus
// Notes:   All numbers used by the design live here
package csps_pkg;
	localparam int          CLK_PERIOD_NS  = 10;
	localparam int          IDENT_TIME_NS  = 2000;
	// Least time: round up to whole cycles
	localparam int          IDENT_CYCLES   = (IDENT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          CNT_W          = 8;

	localparam logic [4:0]  OFS_EVENT      = 5'h00;
	localparam logic [4:0]  OFS_STATUS     = 5'h08;
	localparam logic [4:0]  OFS_FORCE      = 5'h0C;
	localparam logic [4:0]  OFS_POWER      = 5'h14;
	localparam logic [4:0]  OFS_CONFIG     = 5'h18;

	localparam int          BIT_Y_SOCK     = 31;
	localparam int          BIT_X_SOCK     = 30;
	localparam int          BIT_LOW_SOCK   = 29;
	localparam int          BIT_HIGH_SOCK  = 28;
	localparam int          BIT_CAPS_LO    = 10;
	localparam int          BIT_BAD_REQ    = 9;
	localparam int          BIT_LOSS       = 8;
	localparam int          BIT_NOTCARD    = 7;
	localparam int          BIT_READY      = 6;
	localparam int          BIT_WIDE       = 5;
	localparam int          BIT_NARROW     = 4;
	localparam int          BIT_POWERED    = 3;
	localparam int          BIT_DET_B      = 2;
	localparam int          BIT_DET_A      = 1;
	localparam int          BIT_STSCHG     = 0;
	localparam int          BIT_REIDENT    = 14;
	localparam int          BIT_PME_EN     = 0;
	localparam int          BIT_HIGH_DIS   = 1;

	// Event bit order: power, detect b, detect a, status change
	localparam int          EV_POWER       = 3;
	localparam int          EV_DET_B       = 2;
	localparam int          EV_DET_A       = 1;
	localparam int          EV_STSCHG      = 0;

	localparam int          PIN_DET_A      = 0;
	localparam int          PIN_DET_B      = 1;
	localparam int          PIN_STSCHG     = 2;
	localparam int          PIN_READY      = 3;
	localparam int          PIN_VS_LO      = 4;
	localparam int          PIN_W          = 6;

	localparam logic [1:0]  VCC_OFF        = 2'h0;
	localparam logic [1:0]  VCC_HIGH       = 2'h1;
	localparam logic [1:0]  VCC_LOW        = 2'h2;
	localparam logic [1:0]  VCC_BAD        = 2'h3;

	// Identity word {unrecognised, wide bus, narrow, caps y x low high}
	localparam logic [6:0]  ID_VS_3        = 7'h11;
	localparam logic [6:0]  ID_VS_2        = 7'h13;
	localparam logic [6:0]  ID_VS_1        = 7'h22;
	localparam logic [6:0]  ID_VS_0        = 7'h40;

	typedef enum logic [1:0] {
		PH_EMPTY = 2'b00,
		PH_IDENT = 2'b01,
		PH_READY = 2'b10
	} csps_phase_e;

	typedef struct packed {
		logic [PIN_W-1:0] pins_s1;
		logic [PIN_W-1:0] pins_s2;
		logic             stschg_prev;
		logic             ack;
		logic [31:0]      rdata;
		csps_phase_e      phase;
		logic [CNT_W-1:0] cnt;
		logic             det_a;
		logic             det_b;
		logic [3:0]       caps;
		logic             bad_req;
		logic             loss;
		logic             notcard;
		logic             wide;
		logic             narrow;
		logic             powered;
		logic [1:0]       vcc;
		logic [3:0]       events;
		logic             ovr_valid;
		logic [2:0]       ovr;
		logic [1:0]       cfg;
	} csps_state_s;

	localparam csps_state_s CSPS_RESET = '{phase: PH_EMPTY, det_a: 1'b1, det_b: 1'b1,
		pins_s1: 6'h3F, pins_s2: 6'h3F, stschg_prev: 1'b1, default: '0};
endpackage

// [hdl/csps_socket_status.sv]
// Purpose: Socket present-state register with its event, force, power and config words
// Assumes: Card pins are asynchronous; bus_reset_n comes from mclk logic
// Notes:   Status word read-only; force, event, power and config words beside it
// Notes on behaviour
// RL1: Card caps and type change only on insertion. The code also relatches them when a force write sets bit 14 (re-identify).
// RL2: Detect bits frozen during card identification.
// RL3: Force-event writes show in the status word.
// RL4: Bits 31 and 30 zero unless forced.
// RL5: Bit 29 reads one unless forced.
// RL6: Bit 28 one unless high-supply disable set.
// RL7: Bits 27 to 14 read zero.
// RL8: Bits 13 to 10 card caps, force settable.
// RL9: Context bits survive bus reset under PME.
// RL10: Bit 9 flags an invalid supply request.
// RL11: Bit 8 flags possible loss on removal.
// RL12: Bit 7 unrecognised card, kept until valid.
// RL13: Bit 6 is live ready/interrupt level.
// RL14: Bit 5 wide-bus card, set on interrogation.
// RL15: Bit 4 narrow card, set on interrogation.
// RL16: Bit 3 socket powered state, default zero.
// RL17: Bits 2 and 1 follow detect pins.
// RL18: Bit 0 is live status-change level.
// RL19: Changes of powered, detect, status set events. The code counts only rising status edges for wide-bus cards.
// RL20: Forced detect/power events leave live bits.
// RL21: Writes to the status word are ignored.
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module csps_socket_status
	import csps_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic        bus_reset_pin_n,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        card_detect_pin_a,
	input  wire logic        card_detect_pin_b,
	input  wire logic        card_status_change_pin,
	input  wire logic        card_ready_interrupt_pin,
	input  wire logic [1:0]  card_voltage_sense,
	input  wire logic        removal_pending,
	output logic      [1:0]  socket_vcc_select
);
	csps_state_s st;
	csps_state_s next_st;
	logic [31:0] status_word;
	logic        bus_req;
	logic        wr_take;
	logic        card_in;
	logic        force_wr;

	function automatic logic hit(input logic [4:0] addr, input logic [4:0] ofs);
		hit = (addr[4:2] == ofs[4:2]);
	endfunction

	function automatic logic [6:0] identify(input logic [1:0] vs);
		unique case (vs)
			2'b11: identify = ID_VS_3;
			2'b10: identify = ID_VS_2;
			2'b01: identify = ID_VS_1;
			2'b00: identify = ID_VS_0;
		endcase
	endfunction

	function automatic logic supply_ok(input logic [1:0] code, input csps_state_s s,
		input logic [31:0] stat);
		supply_ok = (code == VCC_HIGH && stat[BIT_HIGH_SOCK] && s.caps[0]) ||
			(code == VCC_LOW && stat[BIT_LOW_SOCK] && s.caps[1]);
	endfunction

	assign bus_req         = avs_read | avs_write;
	// One wait state: the answer is ready on the second cycle of every request
	assign avs_waitrequest = bus_req & ~st.ack;
	assign wr_take         = avs_write & st.ack;
	assign force_wr        = wr_take & hit(avs_address, OFS_FORCE);
	assign card_in         = ~st.pins_s2[PIN_DET_A] & ~st.pins_s2[PIN_DET_B];
	assign avs_readdata    = st.rdata;
	assign socket_vcc_select = st.vcc;

	always_comb begin
		status_word = '0;                                                    // see RL7
		status_word[BIT_Y_SOCK]   = st.ovr_valid & st.ovr[2];                // see RL4
		status_word[BIT_X_SOCK]   = st.ovr_valid & st.ovr[1];                // see RL4
		status_word[BIT_LOW_SOCK] = st.ovr_valid ? st.ovr[0] : 1'b1;         // see RL5
		status_word[BIT_HIGH_SOCK] = ~st.cfg[BIT_HIGH_DIS];                  // see RL6
		status_word[BIT_CAPS_LO+3:BIT_CAPS_LO] = st.caps;                    // see RL8
		status_word[BIT_BAD_REQ]  = st.bad_req;
		status_word[BIT_LOSS]     = st.loss;
		status_word[BIT_NOTCARD]  = st.notcard;
		status_word[BIT_READY]    = st.pins_s2[PIN_READY];                  // see RL13
		status_word[BIT_WIDE]     = st.wide;
		status_word[BIT_NARROW]   = st.narrow;
		status_word[BIT_POWERED]  = st.powered;                              // see RL16
		status_word[BIT_DET_B]    = st.det_b;                                // see RL17
		status_word[BIT_DET_A]    = st.det_a;                                // see RL17
		status_word[BIT_STSCHG]   = st.pins_s2[PIN_STSCHG];                 // see RL18
	end

	always_comb begin
		next_st = st;
		next_st.pins_s1 = {card_voltage_sense, card_ready_interrupt_pin, card_status_change_pin,
			card_detect_pin_b, card_detect_pin_a};
		next_st.pins_s2     = st.pins_s1;
		next_st.stschg_prev = st.pins_s2[PIN_STSCHG];
		next_st.ack         = bus_req & ~st.ack;

		// Read data is captured on the first cycle and held through the answer
		if (avs_read & ~st.ack) begin
			if (hit(avs_address, OFS_STATUS))
				next_st.rdata = status_word;
			else if (hit(avs_address, OFS_EVENT))
				next_st.rdata = {28'h0000000, st.events};
			else if (hit(avs_address, OFS_POWER))
				next_st.rdata = {30'h00000000, st.vcc};
			else if (hit(avs_address, OFS_CONFIG))
				next_st.rdata = {30'h00000000, st.cfg};
			else
				next_st.rdata = 32'h00000000;
		end

		// The status word has no write path at all              see RL21
		if (wr_take && hit(avs_address, OFS_CONFIG) && avs_byteenable[0])
			next_st.cfg = avs_writedata[1:0];

		unique case (st.phase)
			PH_EMPTY: begin
				if (card_in) begin
					next_st.phase = PH_IDENT;
					next_st.cnt   = '0;
				end
			end
			PH_IDENT: begin
				if (!card_in) begin
					next_st.phase = PH_EMPTY;
				end else if (st.cnt == CNT_W'(IDENT_CYCLES - 1)) begin
					next_st.phase = PH_READY;
					// Caps and type latch only here              see RL1
					if (identify(st.pins_s2[PIN_VS_LO+1:PIN_VS_LO]) == ID_VS_0) begin
						next_st.notcard = 1'b1;                      // see RL12
					end else begin
						{next_st.notcard, next_st.wide, next_st.narrow, next_st.caps} =
							identify(st.pins_s2[PIN_VS_LO+1:PIN_VS_LO]); // see RL14 RL15
					end
				end else begin
					next_st.cnt = st.cnt + CNT_W'(1);
				end
			end
			PH_READY: begin
				if (!card_in) begin
					next_st.phase = PH_EMPTY;
					if (removal_pending)
						next_st.loss = 1'b1;                             // see RL11
				end else if (force_wr && avs_byteenable[1] && avs_writedata[BIT_REIDENT]) begin
					next_st.phase = PH_IDENT;
					next_st.cnt   = '0;
				end
			end
			default: next_st.phase = PH_EMPTY;
		endcase

		// Pin bounces during identification never reach the detect bits
		// Entry is held off too, so an insertion shows only once identified
		if (st.phase != PH_IDENT && next_st.phase != PH_IDENT) begin // see RL2
			next_st.det_a = st.pins_s2[PIN_DET_A];
			next_st.det_b = st.pins_s2[PIN_DET_B];
		end

		// Power drops with the card; a request is judged against socket and card
		if (st.phase != PH_EMPTY && next_st.phase == PH_EMPTY) begin
			next_st.powered = 1'b0;
			next_st.vcc     = VCC_OFF;
		end else if (wr_take && hit(avs_address, OFS_POWER) && avs_byteenable[0]) begin
			if (avs_writedata[1:0] == VCC_OFF) begin
				next_st.powered = 1'b0;
				next_st.vcc     = VCC_OFF;
				next_st.bad_req = 1'b0;
			end else if (card_in && supply_ok(avs_writedata[1:0], st, status_word)) begin
				next_st.powered = 1'b1;                                  // see RL16
				next_st.vcc     = avs_writedata[1:0];
				next_st.bad_req = 1'b0;
			end else begin
				next_st.powered = 1'b0;
				next_st.vcc     = VCC_OFF;
				next_st.bad_req = 1'b1;                                  // see RL10
			end
		end

		// Force writes set bits, but bits 31 to 29 take the written value; detect and power levels are untouched
		if (force_wr) begin                                              // see RL3
			if (avs_byteenable[3]) begin
				next_st.ovr_valid = 1'b1;                                // see RL4 RL5
				next_st.ovr       = avs_writedata[BIT_Y_SOCK:BIT_LOW_SOCK];
			end
			if (avs_byteenable[1]) begin
				next_st.caps    = next_st.caps | avs_writedata[BIT_CAPS_LO+3:BIT_CAPS_LO]; // see RL8
				next_st.bad_req = next_st.bad_req | avs_writedata[BIT_BAD_REQ];
				next_st.loss    = next_st.loss | avs_writedata[BIT_LOSS];
			end
			if (avs_byteenable[0]) begin
				next_st.notcard = next_st.notcard | avs_writedata[BIT_NOTCARD];
				next_st.wide    = next_st.wide | avs_writedata[BIT_WIDE];
				next_st.narrow  = next_st.narrow | avs_writedata[BIT_NARROW];
			end
		end

		// Write-one clears, but an event in the same cycle wins
		if (wr_take && hit(avs_address, OFS_EVENT) && avs_byteenable[0])
			next_st.events = st.events & ~avs_writedata[3:0];
		if (force_wr && avs_byteenable[0])
			next_st.events = next_st.events | avs_writedata[3:0];        // see RL20
		if (next_st.powered != st.powered)
			next_st.events[EV_POWER] = 1'b1;                             // see RL19
		if (next_st.det_b != st.det_b)
			next_st.events[EV_DET_B] = 1'b1;                             // see RL19
		if (next_st.det_a != st.det_a)
			next_st.events[EV_DET_A] = 1'b1;                             // see RL19
		// Wide-bus cards count rising edges only, others both edges
		if (st.pins_s2[PIN_STSCHG] != st.stschg_prev &&
			(!st.wide || st.pins_s2[PIN_STSCHG]))
			next_st.events[EV_STSCHG] = 1'b1;                            // see RL19

		// Bus reset spares context bits while PME is enabled
		if (!bus_reset_pin_n && !st.cfg[BIT_PME_EN]) begin               // see RL9
			next_st.caps    = CSPS_RESET.caps;
			next_st.bad_req = CSPS_RESET.bad_req;
			next_st.loss    = CSPS_RESET.loss;
			next_st.notcard = CSPS_RESET.notcard;
			next_st.wide    = CSPS_RESET.wide;
			next_st.narrow  = CSPS_RESET.narrow;
			next_st.powered = CSPS_RESET.powered;
			next_st.vcc     = CSPS_RESET.vcc;
			next_st.det_a   = CSPS_RESET.det_a;
			next_st.det_b   = CSPS_RESET.det_b;
			next_st.events  = CSPS_RESET.events;
		end

		if (!reset_n)
			next_st = CSPS_RESET;                                        // see RL9
	end

	always_ff @(posedge mclk) begin
		st <= next_st;
	end

	default clocking cb_main @(posedge mclk); endclocking
	default disable iff (!reset_n);

	sequence insert_seen;
		st.phase == PH_EMPTY && card_in;
	endsequence

	sequence ident_runs;
		st.phase == PH_IDENT && card_in;
	endsequence

	sequence ident_done;
		st.phase == PH_IDENT && card_in && st.cnt == CNT_W'(IDENT_CYCLES - 1);
	endsequence

	wait_one_a: assert property (bus_req && !st.ack |-> avs_waitrequest ##1
		(!bus_req || !avs_waitrequest))
		else $error("bus answer not after one wait state");
	resv_zero_a: assert property (st.ack && avs_read && hit(avs_address, OFS_STATUS)
		|-> avs_readdata[27:14] == 14'h0000) // see RL7
		else $error("reserved status bits not zero");
	ident_start_a: assert property (insert_seen |=> st.phase == PH_IDENT) // see RL1
		else $error("insertion did not start identification");
	det_freeze_a: assert property (ident_runs ##1 ident_runs |-> $stable(st.det_a) &&
		$stable(st.det_b)) // see RL2
		else $error("detect bit moved during identification");
	caps_hold_a: assert property (st.phase == PH_READY && !force_wr && bus_reset_pin_n
		|=> $stable(st.caps) && $stable(st.wide) && $stable(st.narrow)) // see RL1
		else $error("card caps changed outside insertion");
	sock_caps_a: assert property (!st.ovr_valid |-> status_word[BIT_LOW_SOCK] &&
		!status_word[BIT_Y_SOCK] && !status_word[BIT_X_SOCK]) // see RL4
		else $error("socket capability flags wrong");
	high_sock_a: assert property (status_word[BIT_HIGH_SOCK] == !st.cfg[BIT_HIGH_DIS]) // see RL6
		else $error("high supply flag ignores disable");
	bad_req_a: assert property (wr_take && hit(avs_address, OFS_POWER) && avs_byteenable[0]
		&& avs_writedata[1:0] == VCC_BAD |=> st.bad_req && !st.powered) // see RL10
		else $error("invalid supply request not flagged");
	loss_flag_a: assert property (st.phase == PH_READY && !card_in && removal_pending
		|=> st.loss) // see RL11
		else $error("removal loss not flagged");
	ready_live_a: assert property (##2 status_word[BIT_READY] ==
		$past(card_ready_interrupt_pin, 2)) // see RL13
		else $error("ready level not tracking pin");
	stschg_live_a: assert property (##2 status_word[BIT_STSCHG] ==
		$past(card_status_change_pin, 2)) // see RL18
		else $error("status change level not tracking pin");
	det_event_a: assert property (st.det_a != $past(st.det_a) && $past(bus_reset_pin_n)
		|-> st.events[EV_DET_A]) // see RL19
		else $error("detect change lost its event");
	pwr_event_a: assert property (st.powered != $past(st.powered) && $past(bus_reset_pin_n)
		|-> st.events[EV_POWER]) // see RL19
		else $error("power change lost its event");
	force_live_a: assert property (force_wr && st.phase == PH_READY && card_in
		|=> $stable(st.powered)) // see RL20
		else $error("force write moved powered state");
	pme_keep_a: assert property (!bus_reset_pin_n && st.cfg[BIT_PME_EN] && st.notcard
		&& st.phase != PH_IDENT |=> st.notcard) // see RL9
		else $error("context bit lost under PME");
	// Latch checks are gated by bus reset, which may clear the same bits
	ident_end_a: assert property (ident_done |=> st.phase == PH_READY) // see RL1
		else $error("identification did not end on time");
	notcard_set_a: assert property (ident_done and (st.pins_s2[PIN_VS_LO+1:PIN_VS_LO] == 2'b00
		&& bus_reset_pin_n) |=> st.notcard) // see RL12
		else $error("unrecognised card not flagged");
	wide_latch_a: assert property (ident_done and (st.pins_s2[PIN_VS_LO+1:PIN_VS_LO] == 2'b01
		&& bus_reset_pin_n) |=> st.wide && !st.narrow) // see RL14
		else $error("wide-bus card type not latched");
	narrow_latch_a: assert property (ident_done and (st.pins_s2[PIN_VS_LO+1] && bus_reset_pin_n)
		|=> st.narrow && !st.wide) // see RL15
		else $error("narrow card type not latched");
	pwr_state_a: assert property (st.powered == (st.vcc != VCC_OFF)) // see RL16
		else $error("powered state and supply select disagree");
	stschg_ev_a: assert property (st.pins_s2[PIN_STSCHG] != st.stschg_prev && !st.wide
		&& bus_reset_pin_n |=> st.events[EV_STSCHG]) // see RL19
		else $error("status change edge lost its event");
	force_caps_a: assert property (force_wr && avs_byteenable[1] && bus_reset_pin_n
		&& avs_writedata[BIT_CAPS_LO+3] |=> st.caps[3]) // see RL8
		else $error("forced card capability not set");
	force_event_a: assert property (force_wr && avs_byteenable[0] && bus_reset_pin_n
		&& avs_writedata[EV_POWER] |=> st.events[EV_POWER]) // see RL20
		else $error("forced power event not set");
	status_ro_a: assert property (wr_take && hit(avs_address, OFS_STATUS) && bus_reset_pin_n
		&& st.phase == PH_READY && card_in |=> $stable(st.cfg) && $stable(st.vcc)) // see RL21
		else $error("status write changed state");
	det_live_a: assert property (st.phase == PH_READY && $past(st.phase) == PH_READY
		&& $past(bus_reset_pin_n) |-> st.det_a == $past(st.pins_s2[PIN_DET_A])) // see RL17
		else $error("detect bit not following pin");
	bad_clear_a: assert property (wr_take && hit(avs_address, OFS_POWER) && avs_byteenable[0]
		&& avs_writedata[1:0] == VCC_OFF && card_in && bus_reset_pin_n
		|=> !st.bad_req && !st.powered) // see RL10
		else $error("power off request left flags set");
endmodule

// [tb/csps_card_model.sv]
// Purpose: Behavioural card seen from the socket pins
// Assumes: Socket pins have pull-ups, so an empty socket reads high
// Notes:   Levels move only through bench writes made just after mclk edges
`timescale 1ns/1ps
module csps_card_model (
	input  wire logic       inserted,
	input  wire logic [1:0] sense,
	input  wire logic       stschg_lvl,
	input  wire logic       ready_lvl,
	output logic            card_detect_pin_a,
	output logic            card_detect_pin_b,
	output logic            card_status_change_pin,
	output logic            card_ready_interrupt_pin,
	output logic      [1:0] card_voltage_sense
);
	// A removed card leaves every line to its pull-up
	assign card_detect_pin_a        = ~inserted;
	assign card_detect_pin_b        = ~inserted;
	assign card_status_change_pin   = inserted ? stschg_lvl : 1'b1;
	assign card_ready_interrupt_pin = inserted ? ready_lvl : 1'b1;
	assign card_voltage_sense       = inserted ? sense : 2'h3;
endmodule

// [tb/csps_socket_status_tb_top.sv]
// Purpose: Self-checking bench for the socket present-state block
// Assumes: One wait state on every bus access, 200-cycle identification
// Notes:   Status expectation keeps latched bits; live pin bits added on compare
`timescale 1ns/1ps
module csps_socket_status_tb_top;
	import csps_pkg::*;
	logic        mclk, reset_n, bus_reset_pin_n, avs_read, avs_write, avs_waitrequest;
	logic [4:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, st_exp, rd;
	logic [3:0]  avs_byteenable;
	logic        det_a, det_b, stschg, ready, removal_pending, ins, stl, rdl;
	logic [1:0]  vsense, vcc, sns;
	int          num_errors, checked;

	csps_card_model card (.inserted(ins), .sense(sns), .stschg_lvl(stl), .ready_lvl(rdl),
		.card_detect_pin_a(det_a), .card_detect_pin_b(det_b),
		.card_status_change_pin(stschg), .card_ready_interrupt_pin(ready),
		.card_voltage_sense(vsense));

	csps_socket_status dut (.mclk(mclk), .reset_n(reset_n), .bus_reset_pin_n(bus_reset_pin_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.card_detect_pin_a(det_a), .card_detect_pin_b(det_b),
		.card_status_change_pin(stschg), .card_ready_interrupt_pin(ready),
		.card_voltage_sense(vsense), .removal_pending(removal_pending),
		.socket_vcc_select(vcc));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task give_verdict;
		$display("Counts: compares %0d, mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Request held until the edge that sees waitrequest low; one idle edge follows
	task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= ~wr;
		avs_write <= wr;
		// Look at waitrequest once settled; it holds until the next rising edge
		@(negedge mclk);
		while (avs_waitrequest !== 1'b0) begin
			n++;
			if (n > 20) begin
				num_errors++;
				give_verdict;
			end
			@(negedge mclk);
		end
		@(posedge mclk);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge mclk);
	endtask

	task st_chk(input logic [31:0] mask);
		bus(1'b0, OFS_STATUS, 32'h0);
		cmp(rd & mask, (st_exp | (32'(ready) << 6) | 32'(stschg)) & mask);
	endtask

	task ev_chk(input logic [3:0] exp);
		bus(1'b0, OFS_EVENT, 32'h0);
		cmp(rd, {28'h0, exp});
		bus(1'b1, OFS_EVENT, 32'h0000_000F);
	endtask

	task wait_det(input logic [1:0] v);
		int n;
		n = 0;
		do begin
			bus(1'b0, OFS_STATUS, 32'h0);
			n++;
		end while (rd[2:1] !== v && n < 300);
		if (n >= 300) begin
			num_errors++;
			give_verdict;
		end
	endtask

	// Identity word placed in the caps, unrecognised, wide and narrow fields
	function automatic logic [31:0] idw(input logic [6:0] id);
		return {18'h0, id[3:0], 2'h0, id[6], 1'b0, id[5:4], 4'h0};
	endfunction

	task t_reset;
		st_exp = 32'h3000_0006;
		st_chk(32'hFFFF_FFFF);
		ev_chk(4'h0);
		bus(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
		st_chk(32'hFFFF_FFFF);
		bus(1'b0, 5'h1C, 32'h0);
		cmp(rd, 32'h0);
		$display("Test reset and refusal done");
	endtask

	task t_insert;
		ins <= 1'b1;
		sns <= 2'h3;
		repeat (8) @(posedge mclk);
		st_chk(32'hFFFF_FFFF);
		wait_det(2'b00);
		st_exp = 32'h3000_0000 | idw(ID_VS_3);
		st_chk(32'hFFFF_FFFF);
		ev_chk(4'h6);
		sns <= 2'h1;
		repeat (4) @(posedge mclk);
		st_chk(32'hFFFF_FFFF);
		$display("Test insertion done");
	endtask

	task t_live;
		stl <= 1'b0;
		rdl <= 1'b0;
		repeat (4) @(posedge mclk);
		st_chk(32'h0000_0041);
		ev_chk(4'h1);
		rdl <= 1'b1;
		repeat (4) @(posedge mclk);
		st_chk(32'hFFFF_FFFF);
		$display("Test live pins done");
	endtask

	task t_power;
		bus(1'b1, OFS_POWER, {30'h0, VCC_BAD});
		st_exp[9] = 1'b1;
		st_chk(32'hFFFF_FFFF);
		bus(1'b1, OFS_POWER, {30'h0, VCC_HIGH});
		repeat (2) @(posedge mclk);
		st_exp[3] = 1'b1;
		st_exp[9] = 1'b0;
		st_chk(32'hFFFF_FFFF);
		cmp({30'h0, vcc}, {30'h0, VCC_HIGH});
		ev_chk(4'h8);
		$display("Test power done");
	endtask

	task t_force;
		bus(1'b1, OFS_FORCE, 32'hC000_220F);
		st_exp = (st_exp | 32'hC000_2200) & ~32'h2000_0000;
		st_chk(32'hFFFF_FFFF);
		ev_chk(4'hF);
		bus(1'b1, OFS_CONFIG, 32'h0000_0002);
		st_exp[28] = 1'b0;
		st_chk(32'hFFFF_FFFF);
		bus(1'b1, OFS_CONFIG, 32'h0000_0001);
		st_exp[28] = 1'b1;
		bus_reset_pin_n <= 1'b0;
		repeat (2) @(posedge mclk);
		bus_reset_pin_n <= 1'b1;
		@(posedge mclk);
		st_chk(32'hFFFF_FFFF);
		$display("Test force and config done");
	endtask

	task t_remove;
		removal_pending <= 1'b1;
		ins <= 1'b0;
		wait_det(2'b11);
		st_exp = (st_exp | 32'h0000_0106) & ~32'h0000_0008;
		st_chk(32'hFFFF_FFFF);
		cmp({30'h0, vcc}, {30'h0, VCC_OFF});
		ev_chk(4'hF);
		removal_pending <= 1'b0;
		ins <= 1'b1;
		sns <= 2'h0;
		wait_det(2'b00);
		st_exp = (st_exp | idw(ID_VS_0)) & ~32'h0000_0006;
		st_chk(32'hFFFF_FFFF);
		bus(1'b1, OFS_CONFIG, 32'h0);
		bus_reset_pin_n <= 1'b0;
		repeat (2) @(posedge mclk);
		bus_reset_pin_n <= 1'b1;
		@(posedge mclk);
		bus(1'b0, OFS_STATUS, 32'h0);
		cmp(rd & 32'h0000_3FB8, 32'h0);
		$display("Test removal and context clear done");
	endtask

	initial begin
		num_errors = 0;
		checked = 0;
		reset_n = 1'b0;
		bus_reset_pin_n = 1'b1;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
		removal_pending = 1'b0;
		ins = 1'b0;
		sns = 2'h3;
		stl = 1'b1;
		rdl = 1'b1;
		repeat (16) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (3) @(posedge mclk);
		t_reset;
		t_insert;
		t_live;
		t_power;
		t_force;
		t_remove;
		give_verdict;
	end
endmodule
